// ===== rtl/irq_ctrl_with_tick_timer.sv
// interrupt controller: tick time base plus grouped timer match interrupt
// assumes core handshake and bus signals come from the system clock domain
// except sub_clock, which is a pin and is synchronised here
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_with_tick_timer
    import irq_tick_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        sub_clock,
    input  wire logic        cmp_p_match,
    input  wire logic        cmp_a_match,
    input  wire logic        stack_full,
    input  wire logic        irq_ack,
    input  wire logic        ret_from_irq,
    input  wire logic        ret_plain,
    output logic             irq_req,
    output logic [1:0]       irq_vector,
    output logic             push_pc_only,
    output logic             wake_up,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef struct packed {
        logic [1:0]  src_sel;
        logic        tick_run;
        logic [2:0]  tick_period_sel;
        logic        tick_irq_flag;
        logic        tick_irq_enable;
        logic        global_irq_enable;
        logic        group_irq_flag;
        logic        group_irq_enable;
        logic        cmp_a_match_flag;
        logic        cmp_p_match_flag;
        logic        cmp_a_match_enable;
        logic        cmp_p_match_enable;
        logic [15:0] tick_count;
        logic [1:0]  sys_div;
        logic [1:0]  sub_sync;
        logic        sub_last;
        logic [3:0]  flag_last;
        logic        irq_req;
        logic [1:0]  irq_vector;
        logic        push_pc_only;
        logic        wake_up;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        bus_state_e  wr_state;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic        arready;
    } state_s;

    state_s cur;
    state_s next_cur;

    // the bus has to look ready straight out of reset, so those flops reset high
    localparam state_s CUR_RESET = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                     wr_state: BUS_IDLE, default: '0};

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == ADDR_SRC_SEL) || (a == ADDR_TICK_CTRL) ||
                     (a == ADDR_IRQ_FIRST) || (a == ADDR_IRQ_SECOND) ||
                     (a == ADDR_GROUP) || (a == ADDR_CPU_STAT);
    endfunction

    // unimplemented bits are simply never placed, so they read zero
    function automatic logic [7:0] reg_view(input state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_SRC_SEL:    v[1:0] = s.src_sel;
            ADDR_TICK_CTRL: begin
                v[TICK_RUN_BIT] = s.tick_run;
                v[2:0]          = s.tick_period_sel;
            end
            ADDR_IRQ_FIRST: begin
                v[TICK_FLAG_BIT] = s.tick_irq_flag;
                v[TICK_EN_BIT]   = s.tick_irq_enable;
                v[GLOBAL_EN_BIT] = s.global_irq_enable;
            end
            ADDR_IRQ_SECOND: begin
                v[GROUP_FLAG_BIT] = s.group_irq_flag;
                v[GROUP_EN_BIT]   = s.group_irq_enable;
            end
            ADDR_GROUP: begin
                v[A_FLAG_BIT] = s.cmp_a_match_flag;
                v[P_FLAG_BIT] = s.cmp_p_match_flag;
                v[A_EN_BIT]   = s.cmp_a_match_enable;
                v[P_EN_BIT]   = s.cmp_p_match_enable;
            end
            ADDR_CPU_STAT:   v[1:0] = {s.irq_req, s.wake_up};
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    logic        wr_fire;
    logic        wr_lane0;
    logic [7:0]  wv;
    logic        prescale_tick;
    logic [15:0] period_last;
    logic        tick_ovf;
    logic        member_set;
    logic        group_req;
    logic        tick_req;
    logic        take;
    logic [3:0]  flags_now;

    always_comb begin
        next_cur = cur;
        wr_fire  = 1'b0;
        wr_lane0 = 1'b0;
        wv       = cur.w_data[7:0];

        next_cur.sub_sync = {cur.sub_sync[0], sub_clock};
        next_cur.sub_last = cur.sub_sync[1];
        next_cur.sys_div  = cur.sys_div + 2'h1;
        case (cur.src_sel)
            SRC_SYS:     prescale_tick = 1'b1;
            SRC_SYS_DIV: prescale_tick = (cur.sys_div == SYS_DIV_LAST);
            default:     prescale_tick = cur.sub_sync[1] & ~cur.sub_last;
        endcase
        // period is a power of two, so the last count is a low-bit mask
        period_last = 16'((32'h1 << (PERIOD_BASE + int'(cur.tick_period_sel))) - 32'h1);
        tick_ovf = cur.tick_run && prescale_tick && (cur.tick_count == period_last);
        if (!cur.tick_run) begin
            next_cur.tick_count = 16'h0000;
        end else if (prescale_tick) begin
            next_cur.tick_count = tick_ovf ? 16'h0000 : cur.tick_count + 16'h0001;
        end

        // AXI write: address and data in either order
        if (s_axi_awvalid && !cur.aw_got && cur.wr_state == BUS_IDLE) begin
            next_cur.aw_got  = 1'b1;
            next_cur.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur.w_got && cur.wr_state == BUS_IDLE) begin
            next_cur.w_got  = 1'b1;
            next_cur.w_data = s_axi_wdata;
            next_cur.w_strb = s_axi_wstrb;
        end
        case (cur.wr_state)
            BUS_IDLE: begin
                if (cur.aw_got && cur.w_got) begin
                    wr_fire           = 1'b1;
                    wr_lane0          = cur.w_strb[0] && addr_known(cur.aw_addr);
                    next_cur.bresp    = addr_known(cur.aw_addr) ? RESP_OKAY : RESP_SLVERR;
                    next_cur.wr_state = BUS_RESP;
                    next_cur.aw_got   = 1'b0;
                    next_cur.w_got    = 1'b0;
                end
            end
            BUS_RESP: begin
                if (s_axi_bready) begin
                    next_cur.wr_state = BUS_IDLE;
                end
            end
            default: next_cur.wr_state = BUS_IDLE;
        endcase
        if (!cur.rvalid && s_axi_arvalid) begin
            next_cur.rvalid = 1'b1;
            next_cur.rdata  = {24'h000000, reg_view(cur, s_axi_araddr)};
            next_cur.rresp  = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        // handshake outputs are registered copies of the next bus state
        next_cur.awready = !next_cur.aw_got && next_cur.wr_state == BUS_IDLE;
        next_cur.wready  = !next_cur.w_got && next_cur.wr_state == BUS_IDLE;
        next_cur.bvalid  = next_cur.wr_state == BUS_RESP;
        next_cur.arready = !next_cur.rvalid;

        // software writes first, hardware sets after, so a set wins
        if (wr_lane0) begin
            case (cur.aw_addr)
                ADDR_SRC_SEL:   next_cur.src_sel = wv[1:0];
                ADDR_TICK_CTRL: begin
                    next_cur.tick_run        = wv[TICK_RUN_BIT];
                    next_cur.tick_period_sel = wv[2:0];
                end
                ADDR_IRQ_FIRST: begin
                    next_cur.tick_irq_flag     = wv[TICK_FLAG_BIT];
                    next_cur.tick_irq_enable   = wv[TICK_EN_BIT];
                    next_cur.global_irq_enable = wv[GLOBAL_EN_BIT];
                end
                ADDR_IRQ_SECOND: begin
                    next_cur.group_irq_flag   = wv[GROUP_FLAG_BIT];
                    next_cur.group_irq_enable = wv[GROUP_EN_BIT];
                end
                ADDR_GROUP: begin
                    next_cur.cmp_a_match_flag   = wv[A_FLAG_BIT];
                    next_cur.cmp_p_match_flag   = wv[P_FLAG_BIT];
                    next_cur.cmp_a_match_enable = wv[A_EN_BIT];
                    next_cur.cmp_p_match_enable = wv[P_EN_BIT];
                end
                default: ;
            endcase
        end

        // requests: tick and group flags stay until serviced or written, member flags until written
        member_set = (cmp_p_match && !cur.cmp_p_match_flag) ||
                     (cmp_a_match && !cur.cmp_a_match_flag);
        tick_req  = cur.global_irq_enable && cur.tick_irq_enable && cur.tick_irq_flag;
        group_req = cur.global_irq_enable && cur.group_irq_enable && cur.group_irq_flag &&
                    ((cur.cmp_p_match_flag && cur.cmp_p_match_enable) ||
                     (cur.cmp_a_match_flag && cur.cmp_a_match_enable));
        // tick ranks ahead of the group vector on simultaneous requests
        next_cur.irq_req    = (tick_req || group_req) && !stack_full && !cur.irq_req;
        next_cur.irq_vector = tick_req ? VEC_TICK : VEC_GROUP;
        next_cur.push_pc_only = next_cur.irq_req;
        take = cur.irq_req && irq_ack;
        if (take) begin
            next_cur.global_irq_enable = 1'b0;
            if (cur.irq_vector == VEC_TICK) begin
                next_cur.tick_irq_flag = 1'b0;
            end else begin
                next_cur.group_irq_flag = 1'b0;
            end
        end
        if (ret_from_irq) begin
            next_cur.global_irq_enable = 1'b1;
        end
        // ret_plain leaves the global enable where it is
        if (ret_plain) begin
            next_cur.global_irq_enable = next_cur.global_irq_enable;
        end

        if (cmp_p_match) next_cur.cmp_p_match_flag = 1'b1;
        if (cmp_a_match) next_cur.cmp_a_match_flag = 1'b1;
        if (member_set)  next_cur.group_irq_flag = 1'b1;
        if (tick_ovf)    next_cur.tick_irq_flag = 1'b1;

        flags_now = {cur.tick_irq_flag, cur.group_irq_flag,
                     cur.cmp_a_match_flag, cur.cmp_p_match_flag};
        next_cur.flag_last = flags_now;
        next_cur.wake_up   = |(flags_now & ~cur.flag_last);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cur <= CUR_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign irq_req       = cur.irq_req;
    assign irq_vector    = cur.irq_vector;
    assign push_pc_only  = cur.push_pc_only;
    assign wake_up       = cur.wake_up;
    assign s_axi_awready = cur.awready;
    assign s_axi_wready  = cur.wready;
    assign s_axi_bvalid  = cur.bvalid;
    assign s_axi_bresp   = cur.bresp;
    assign s_axi_arready = cur.arready;
    assign s_axi_rvalid  = cur.rvalid;
    assign s_axi_rdata   = cur.rdata;
    assign s_axi_rresp   = cur.rresp;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_group_sets: assert property (member_set |=> cur.group_irq_flag)
        else $error("group flag not set by member");
    a_tick_flag: assert property (tick_ovf |=> cur.tick_irq_flag)
        else $error("tick flag not set on overflow");
    a_take_clears: assert property (take && !ret_from_irq |=> !cur.global_irq_enable)
        else $error("global enable kept after service");
    a_member_kept: assert property (take && cur.cmp_p_match_flag |=> cur.cmp_p_match_flag)
        else $error("member flag cleared by service");
    a_full_holds: assert property (stack_full && !cur.irq_req |=> !cur.irq_req)
        else $error("request raised on full stack");
    a_tick_gate: assert property (cur.irq_req && cur.irq_vector == VEC_TICK |->
        $past(cur.global_irq_enable) && $past(cur.tick_irq_enable))
        else $error("tick vector without enables");
    a_return_from_irq_sets: assert property (ret_from_irq |=> cur.global_irq_enable)
        else $error("return from irq left enable low");
    a_wake_edge: assert property ($rose(cur.tick_irq_flag) |=> wake_up)
        else $error("no wake on flag rise");
    a_stop_count: assert property (!cur.tick_run |=> cur.tick_count == 16'h0000)
        else $error("tick counter runs while stopped");

    // service, gating, flag-set, counter, wake and bus checks; same-cycle software writes are left out
    a_write_resp: assert property (wr_fire |=> s_axi_bvalid)
        else $error("write response missing");
    a_p_match: assert property (cmp_p_match |=> cur.cmp_p_match_flag)
        else $error("P match flag not set");
    a_a_match: assert property (cmp_a_match |=> cur.cmp_a_match_flag)
        else $error("A match flag not set");
    a_group_gate: assert property (cur.irq_req && cur.irq_vector == VEC_GROUP |->
        $past(cur.global_irq_enable) && $past(cur.group_irq_enable))
        else $error("group vector without enables");
    a_group_clear: assert property (take && cur.irq_vector == VEC_GROUP && !member_set &&
        !wr_lane0 |=> !cur.group_irq_flag)
        else $error("group flag kept after service");
    a_tick_clear: assert property (take && cur.irq_vector == VEC_TICK && !tick_ovf &&
        !wr_lane0 |=> !cur.tick_irq_flag)
        else $error("tick flag kept after service");
    a_member_a_kept: assert property (take && cur.cmp_a_match_flag && !wr_lane0 |=>
        cur.cmp_a_match_flag)
        else $error("A flag cleared by service");
    a_flag_holds: assert property (cur.tick_irq_flag && !take && !wr_lane0 |=>
        cur.tick_irq_flag)
        else $error("tick flag dropped on its own");
    a_plain_ret: assert property (ret_plain && !ret_from_irq && !wr_lane0 &&
        !cur.global_irq_enable |=> !cur.global_irq_enable)
        else $error("plain return raised global enable");
    a_tick_restart: assert property (tick_ovf |=> cur.tick_count == 16'h0000)
        else $error("tick counter not restarted");
    a_wake_group: assert property ($rose(cur.group_irq_flag) |=> wake_up)
        else $error("no wake on group flag rise");
    a_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    c_tick_take: cover property (take && cur.irq_vector == VEC_TICK);
    c_group_take: cover property (take && cur.irq_vector == VEC_GROUP);
    c_wake: cover property (wake_up);
    c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_full_wait: cover property (stack_full && (tick_req || group_req));

endmodule // irq_ctrl_with_tick_timer
`default_nettype wire

// ===== rtl/irq_tick_pkg.sv
// constants for the interrupt controller with tick timer
// assumes a single 50 MHz system clock and an AXI4-Lite register master
package irq_tick_pkg;
    localparam logic [7:0] ADDR_SRC_SEL    = 8'h00;
    localparam logic [7:0] ADDR_TICK_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_FIRST  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_SECOND = 8'h0C;
    localparam logic [7:0] ADDR_GROUP      = 8'h10;
    localparam logic [7:0] ADDR_CPU_STAT   = 8'h14;

    localparam int TICK_RUN_BIT    = 7;
    localparam int TICK_FLAG_BIT   = 5;
    localparam int TICK_EN_BIT     = 2;
    localparam int GLOBAL_EN_BIT   = 0;
    localparam int GROUP_FLAG_BIT  = 4;
    localparam int GROUP_EN_BIT    = 0;
    localparam int A_FLAG_BIT      = 5;
    localparam int P_FLAG_BIT      = 4;
    localparam int A_EN_BIT        = 1;
    localparam int P_EN_BIT        = 0;

    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [1:0] SRC_SYS     = 2'h0;
    localparam logic [1:0] SRC_SYS_DIV = 2'h1;
    localparam int         PERIOD_BASE = 8;
    localparam logic [1:0] SYS_DIV_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] VEC_TICK    = 2'h1;
    localparam logic [1:0] VEC_GROUP   = 2'h2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } bus_state_e;
endpackage

// ===== sim/cpu_core_model.sv
// behavioural core: answers interrupt requests and keeps the return stack
// assumes return pulses come from the bench on the system clock
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model #(
    parameter int DEPTH = 1
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       irq_req,
    input  wire logic [1:0] irq_vector,
    input  wire logic       push_pc_only,
    input  wire logic       ack_en,
    input  wire logic       ret_from_irq,
    input  wire logic       ret_plain,
    output logic            irq_ack,
    output logic            stack_full,
    output int              depth,
    output logic [1:0]      last_vec
);
    // a slow core leaves a request unanswered and the block asks again
    assign irq_ack    = irq_req & ack_en;
    assign stack_full = depth >= DEPTH;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            depth    <= 0;
            last_vec <= 2'h0;
        end else if (irq_ack && push_pc_only) begin
            // only the return address is stacked, no calls from service code
            depth    <= depth + 1;
            last_vec <= irq_vector;
        end else if ((ret_from_irq || ret_plain) && depth > 0) begin
            depth <= depth - 1;
        end
    end
endmodule // cpu_core_model
`default_nettype wire

// ===== sim/irq_ctrl_with_tick_timer_tb.sv
// self-checking bench: register table, tick periods, tick and grouped service
// assumes the core model acknowledges requests; bench drives bus, match and return pins
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_with_tick_timer_tb
    import irq_tick_pkg::*;
;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_s;
    logic        sys_clk = 0, reset_n = 0, sub_clock = 0, ack_en = 0, irq_ack, stack_full;
    logic        irq_req, push_pc_only, wake_up, awready, wready, bvalid, arready, rvalid;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [1:0]  irq_vector, last_vec, rsp, bresp, rresp;
    logic [3:0]  pls = 4'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    int          num_errors = 0, compares = 0, cyc = 0, wakes = 0, irqs = 0;
    int          last_wake = 0, prev_wake = 0, depth, s, t;
    row_s        rows [5];

    always #10 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #50 sub_clock = ~sub_clock;
    end
    always @(posedge sys_clk) begin
        cyc  <= cyc + 1;
        irqs <= irqs + int'(irq_req);
        if (wake_up) begin
            wakes     <= wakes + 1;
            prev_wake <= last_wake;
            last_wake <= cyc;
        end
    end

    irq_ctrl_with_tick_timer u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .sub_clock(sub_clock), .cmp_p_match(pls[0]),
        .cmp_a_match(pls[1]), .stack_full(stack_full), .irq_ack(irq_ack),
        .ret_from_irq(pls[2]), .ret_plain(pls[3]), .irq_req(irq_req), .irq_vector(irq_vector),
        .push_pc_only(push_pc_only), .wake_up(wake_up), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    cpu_core_model #(.DEPTH(1)) u_core (
        .sys_clk(sys_clk), .reset_n(reset_n), .irq_req(irq_req), .irq_vector(irq_vector),
        .push_pc_only(push_pc_only), .ack_en(ack_en), .ret_from_irq(pls[2]),
        .ret_plain(pls[3]), .irq_ack(irq_ack), .stack_full(stack_full), .depth(depth),
        .last_vec(last_vec)
    );

    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        int n;
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw = 0;
        w  = 0;
        n  = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (awready && !aw) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wready && !w) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end while (!bvalid && n < 1000);
        if (!bvalid) num_errors++;
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        int n;
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (arready) begin
                arvalid <= 1'b0;
            end
        end while (!rvalid && n < 1000);
        if (!rvalid) num_errors++;
        rsp = rresp;
        rready <= 1'b0;
        check(rdata, e);
    endtask
    task pulse(input logic [3:0] m);
        @(posedge sys_clk);
        pls <= m;
        @(posedge sys_clk);
        pls <= 4'h0;
    endtask
    // gap between two flag rises; the first rise after a change is ignored
    task tick_gap(input logic [1:0] src, input logic [2:0] sel, input int exp);
        int w0, n;
        wr(ADDR_SRC_SEL, {30'h0, src});
        wr(ADDR_TICK_CTRL, {24'h0, 5'h10, sel});
        w0 = wakes;
        for (int k = 1; k <= 2; k++) begin
            wr(ADDR_IRQ_FIRST, 32'h0);
            n = 0;
            while (wakes < w0 + k && n < 70000) begin
                @(posedge sys_clk);
                n++;
            end
            if (wakes < w0 + k) num_errors++;
        end
        check(last_wake - prev_wake, exp);
    endtask
    task results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rows = '{'{ADDR_SRC_SEL, 32'hFF, 32'h03}, '{ADDR_TICK_CTRL, 32'hFF, 32'h87},
                 '{ADDR_IRQ_FIRST, 32'hFF, 32'h25}, '{ADDR_IRQ_SECOND, 32'hFF, 32'h11},
                 '{ADDR_GROUP, 32'hFF, 32'h33}};
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].e);
            check(32'(rsp), 32'(RESP_OKAY));
        end
        reset_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        wr(8'h18, 32'hFF);
        check(32'(rsp), 32'(RESP_SLVERR));
        rd_chk(8'h18, 32'h0);
        check(32'(rsp), 32'(RESP_SLVERR));
        for (int i = 0; i < 6; i++) begin
            rd_chk(8'(4 * i), 32'h0);
        end
        // longest period first, while the counter still starts from zero
        tick_gap(SRC_SYS, 3'h7, 32768);
        tick_gap(SRC_SYS, 3'h0, 256);
        tick_gap(SRC_SYS, 3'h1, 512);
        tick_gap(SRC_SYS_DIV, 3'h0, 1024);
        tick_gap(2'h2, 3'h0, 1280);
        tick_gap(2'h3, 3'h0, 1280);
        wr(ADDR_IRQ_FIRST, 32'h20);
        s = wakes;
        repeat (600) @(posedge sys_clk);
        check(wakes - s, 0);
        wr(ADDR_TICK_CTRL, 32'h0);
        wr(ADDR_IRQ_FIRST, 32'h0);
        s = wakes;
        repeat (600) @(posedge sys_clk);
        check(wakes - s, 0);
        t = irqs;
        wr(ADDR_IRQ_FIRST, 32'h24);
        repeat (20) @(posedge sys_clk);
        check(irqs - t, 0);
        wr(ADDR_IRQ_FIRST, 32'h25);
        repeat (20) @(posedge sys_clk);
        rd_chk(ADDR_IRQ_FIRST, 32'h25);
        ack_en <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd_chk(ADDR_IRQ_FIRST, 32'h04);
        check(32'(last_vec), 32'(VEC_TICK));
        check(depth, 1);
        pulse(4'h4);
        rd_chk(ADDR_IRQ_FIRST, 32'h05);
        wr(ADDR_IRQ_FIRST, 32'h25);
        repeat (10) @(posedge sys_clk);
        pulse(4'h8);
        rd_chk(ADDR_IRQ_FIRST, 32'h04);
        ack_en <= 1'b0;
        wr(ADDR_IRQ_FIRST, 32'h01);
        wr(ADDR_GROUP, 32'h01);
        wr(ADDR_IRQ_SECOND, 32'h01);
        pulse(4'h1);
        rd_chk(ADDR_GROUP, 32'h11);
        rd_chk(ADDR_IRQ_SECOND, 32'h11);
        ack_en <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd_chk(ADDR_IRQ_SECOND, 32'h01);
        rd_chk(ADDR_GROUP, 32'h11);
        check(32'(last_vec), 32'(VEC_GROUP));
        wr(ADDR_GROUP, 32'h01);
        pulse(4'h4);
        s = wakes;
        t = irqs;
        pulse(4'h2);
        repeat (20) @(posedge sys_clk);
        check(32'(wakes > s), 32'h1);
        check(irqs - t, 0);
        rd_chk(ADDR_GROUP, 32'h21);
        wr(ADDR_GROUP, 32'h23);
        repeat (10) @(posedge sys_clk);
        check(depth, 1);
        t = irqs;
        wr(ADDR_IRQ_FIRST, 32'h25);
        repeat (20) @(posedge sys_clk);
        check(irqs - t, 0);
        pulse(4'h8);
        repeat (10) @(posedge sys_clk);
        check(32'(last_vec), 32'(VEC_TICK));
        results();
    end
    initial begin
        #(95000 * 20);
        num_errors++;
        results();
    end
endmodule // irq_ctrl_with_tick_timer_tb
`default_nettype wire
